// *** rtl/seq_defs.svh ***
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ----------------------------------------
// Serial clock and phase sizing
// ----------------------------------------
// System clocks per serial clock half period (sclk = clk / 4)
`define SCLK_HALF 3'h2
`define SCLK_HALF_LAST 3'h1
// Bits in one command byte, one address of each length, one byte
`define CMD_BITS 20'h0_0008
`define ADDR24_BITS 20'h0_0018
`define ADDR32_BITS 20'h0_0020
`define BYTE_BITS 4'h8
// Option bytes available, and phase counter width
`define OPT_MAX 3'h4
`define CNT_W 20
// Receive FIFO geometry
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8

// ----------------------------------------
// Pin levels
// ----------------------------------------
// Output enables, active low: none, line 0 only, all four
`define OE_NONE 4'hF
`define OE_LINE0 4'hE
`define OE_ALL 4'h0
// Single-line mode reads the flash output on line 1
`define MISO_LINE 1

`endif

// *** rtl/seq_pkg.sv ***
package seq_pkg;

  // Phase states, Gray coded along the command path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b011,
    ST_OPT   = 3'b010,
    ST_DUMMY = 3'b110,
    ST_DATA  = 3'b111,
    ST_DONE  = 3'b101
  } phase_t;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] quad_t;

endpackage

// *** rtl/byte_stream_if.sv ***
`timescale 1ns/1ps

// Valid/ready byte stream between sequencer and receive FIFO
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/byte_fifo.sv ***
`timescale 1ns/1ps

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  // ----------------------------------------
  // Handshake and pointers
  // ----------------------------------------
  assign fill.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign drain.valid = (cnt_reg != '0);
  assign drain.data = mem[rptr_reg];
  assign do_push = fill.valid && fill.ready;
  assign do_pop = drain.valid && drain.ready;

  // Wrap explicitly so a depth that is not a power of two still works
  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    if (do_push) begin
      wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
    end
    if (do_pop) begin
      rptr_next = (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
    end
    if (do_push && !do_pop) begin
      cnt_next = cnt_reg + (AW+1)'(1);
    end else if (do_pop && !do_push) begin
      cnt_next = cnt_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage carries no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr_reg] <= fill.data;
    end
  end

endmodule

// *** rtl/flash_cmd_sequencer.sv ***
// Notes on behaviour
// - Software may leave out the dummy phase, and then the data phase follows directly.
// - Dummy cycles drive either line 0 alone or all four lines, as software selects.
// - The dummy phase lasts from one to eight serial clocks as set by its count field.
// - Received data are sampled from one line or from four lines in parallel.
// - Received data are captured on the rising edge only, or on both serial clock edges.
// - In manual mode instruction fetches from the mapped flash space are refused.
// - Pin waveforms of a manual command follow from the configuration inputs; in the data phase sclk also waits for receive FIFO space.
// - The option phase sends none or the first one to four option bytes, first byte first.
// - The address phase sends a 24-bit or a 32-bit address, as selected.
`timescale 1ns/1ps
`include "seq_defs.svh"

module flash_cmd_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manual_mode,
  input wire logic start,
  input wire seq_pkg::byte_t cmd_code,
  input wire logic addr_en,
  input wire logic [31:0] addr,
  input wire logic addr_32,
  input wire logic addr_quad,
  input wire logic [2:0] opt_count,
  input wire logic opt_quad,
  input wire seq_pkg::byte_t option_byte_first,
  input wire seq_pkg::byte_t option_byte_second,
  input wire seq_pkg::byte_t option_byte_third,
  input wire seq_pkg::byte_t option_byte_fourth,
  input wire logic dummy_en,
  input wire logic dummy_quad,
  input wire logic [2:0] dummy_cycles,
  input wire logic data_quad,
  input wire logic data_ddr,
  input wire logic [15:0] data_bytes,
  input wire logic fetch_req,
  input wire seq_pkg::quad_t io_in,
  input wire logic rx_ready,
  output logic busy,
  output logic fetch_refused,
  output logic cs_n,
  output logic sclk,
  output seq_pkg::quad_t io_out,
  output seq_pkg::quad_t io_oe_n,
  output seq_pkg::byte_t rx_data,
  output logic rx_valid
);
  import seq_pkg::*;

  phase_t state_reg, state_next, ld_phase;
  phase_t after_cmd, after_addr, after_opt, after_dummy;
  logic [2:0] div_reg, div_next;
  logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, busy_reg, busy_next;
  logic [31:0] sr_reg, sr_next, ld_sr;
  logic [`CNT_W-1:0] cnt_reg, cnt_next, ld_cnt, ld_bits;
  logic w4_reg, w4_next, ld_w4;
  quad_t io_out_reg, io_out_next, oe_n_reg, oe_n_next;
  quad_t sync1_reg, sync2_reg;
  byte_t acc_reg, acc_next, push_data_reg, push_data_next;
  logic [3:0] nbits_reg, nbits_next;
  logic push_valid_reg, push_valid_next, refused_reg, refused_next;
  byte_t out_data_reg, out_data_next;
  logic out_valid_reg, out_valid_next;
  logic tick, rise, fall, stall, sample, sample_reg, sample_w4_reg;
  logic [2:0] opt_n;

  byte_stream_if #(.W(`FIFO_WIDTH)) push_s ();
  byte_stream_if #(.W(`FIFO_WIDTH)) pop_s ();

  byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .fill(push_s),
    .drain(pop_s)
  );

  // ----------------------------------------
  // Phase order and per-phase load values
  // ----------------------------------------
  // Disabled phases are skipped, order stays fixed
  assign opt_n = (opt_count > `OPT_MAX) ? `OPT_MAX : opt_count;
  assign after_dummy = (data_bytes != '0) ? ST_DATA : ST_DONE;
  assign after_opt = dummy_en ? ST_DUMMY : after_dummy;
  assign after_addr = (opt_n != '0) ? ST_OPT : after_opt;
  assign after_cmd = addr_en ? ST_ADDR : after_addr;

  always_comb begin
    ld_phase = ST_CMD;
    ld_sr = '0;
    ld_bits = '0;
    ld_cnt = `CNT_W'(1);
    ld_w4 = 1'b0;
    unique case (state_reg)
      ST_CMD: ld_phase = after_cmd;
      ST_ADDR: ld_phase = after_addr;
      ST_OPT: ld_phase = after_opt;
      ST_DUMMY: ld_phase = after_dummy;
      ST_DATA: ld_phase = ST_DONE;
      default: ld_phase = ST_CMD;
    endcase
    unique case (ld_phase)
      ST_CMD: begin
        ld_sr = {cmd_code, 24'h00_0000};
        ld_cnt = `CMD_BITS;
      end
      ST_ADDR: begin
        ld_sr = addr_32 ? addr : {addr[23:0], 8'h00};
        ld_bits = addr_32 ? `ADDR32_BITS : `ADDR24_BITS;
        ld_w4 = addr_quad;
        ld_cnt = ld_w4 ? (ld_bits >> 2) : ld_bits;
      end
      ST_OPT: begin
        // First byte leaves first, later bytes follow downward
        ld_sr = {option_byte_first, option_byte_second,
                 option_byte_third, option_byte_fourth};
        ld_bits = {14'h0000, opt_n, 3'h0};
        ld_w4 = opt_quad;
        ld_cnt = ld_w4 ? (ld_bits >> 2) : ld_bits;
      end
      ST_DUMMY: begin
        ld_w4 = dummy_quad;
        ld_cnt = {17'h0_0000, dummy_cycles} + `CNT_W'(1);
      end
      ST_DATA: begin
        ld_bits = {1'b0, data_bytes, 3'h0};
        ld_w4 = data_quad;
        ld_cnt = (ld_w4 ? (ld_bits >> 2) : ld_bits) >> data_ddr;
      end
      default: ld_cnt = `CNT_W'(1);
    endcase
  end

  // ----------------------------------------
  // Sequencer, serial clock and receive path
  // ----------------------------------------
  // A full FIFO freezes the data phase clock rather than dropping bytes; other phases run on
  assign stall = push_valid_reg && !push_s.ready && (state_reg == ST_DATA);
  assign tick = busy_reg && !stall && (div_reg == `SCLK_HALF_LAST);
  assign rise = tick && !sclk_reg && (state_reg != ST_DONE);
  assign fall = tick && sclk_reg;
  assign sample = (state_reg == ST_DATA) && (rise || (fall && data_ddr));

  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    busy_next = busy_reg;
    sr_next = sr_reg;
    cnt_next = cnt_reg;
    w4_next = w4_reg;
    acc_next = acc_reg;
    nbits_next = nbits_reg;
    push_valid_next = push_valid_reg;
    push_data_next = push_data_reg;
    refused_next = manual_mode && fetch_req;
    if (state_reg == ST_IDLE) begin
      // Commands only start in manual mode
      if (start && manual_mode) begin
        state_next = ST_CMD;
        sr_next = ld_sr;
        cnt_next = ld_cnt;
        w4_next = ld_w4;
        cs_n_next = 1'b0;
        busy_next = 1'b1;
        div_next = '0;
        nbits_next = '0;
      end
    end else begin
      if (!stall) begin
        div_next = tick ? 3'h0 : div_reg + 3'h1;
      end
      if (rise) begin
        sclk_next = 1'b1;
      end
      if (fall) begin
        sclk_next = 1'b0;
      end
      if (state_reg == ST_DONE) begin
        if (tick) begin
          state_next = ST_IDLE;
          busy_next = 1'b0;
        end
      end else if (fall) begin
        if (cnt_reg == `CNT_W'(1)) begin
          state_next = ld_phase;
          sr_next = ld_sr;
          cnt_next = ld_cnt;
          w4_next = ld_w4;
          cs_n_next = (ld_phase == ST_DONE);
        end else begin
          sr_next = w4_reg ? {sr_reg[27:0], 4'h0} : {sr_reg[30:0], 1'b0};
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
    end
    // Accepted byte clears first so a new byte in the same cycle wins
    if (push_valid_reg && push_s.ready) begin
      push_valid_next = 1'b0;
    end
    if (sample_reg) begin // One clock late: the pin level needs the sync delay
      acc_next = sample_w4_reg ? {acc_reg[3:0], sync2_reg}
                               : {acc_reg[6:0], sync2_reg[`MISO_LINE]};
      nbits_next = nbits_reg + (sample_w4_reg ? 4'h4 : 4'h1);
      if (nbits_next == `BYTE_BITS) begin
        push_valid_next = 1'b1;
        push_data_next = acc_next;
        nbits_next = '0;
      end
    end
  end

  // Pin drive follows the phase that will be active next cycle
  always_comb begin
    io_out_next = '0;
    oe_n_next = `OE_NONE;
    unique case (state_next)
      ST_CMD, ST_ADDR, ST_OPT, ST_DUMMY: begin
        io_out_next = w4_next ? sr_next[31:28] : {3'h0, sr_next[31]};
        oe_n_next = w4_next ? `OE_ALL : `OE_LINE0;
      end
      default: oe_n_next = `OE_NONE;
    endcase
  end

  // Output stage keeps the receive outputs straight from flops
  assign pop_s.ready = !out_valid_reg || rx_ready;
  assign push_s.valid = push_valid_reg;
  assign push_s.data = push_data_reg;

  always_comb begin
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    if (pop_s.ready) begin
      out_valid_next = pop_s.valid;
      out_data_next = pop_s.valid ? pop_s.data : out_data_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      div_reg <= '0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      sr_reg <= '0;
      cnt_reg <= '0;
      w4_reg <= 1'b0;
      io_out_reg <= '0;
      oe_n_reg <= `OE_NONE;
      sync1_reg <= '0;
      sync2_reg <= '0;
      sample_reg <= 1'b0;
      sample_w4_reg <= 1'b0;
      acc_reg <= '0;
      nbits_reg <= '0;
      push_valid_reg <= 1'b0;
      push_data_reg <= '0;
      refused_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      busy_reg <= busy_next;
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
      w4_reg <= w4_next;
      io_out_reg <= io_out_next;
      oe_n_reg <= oe_n_next;
      sync1_reg <= io_in;
      sync2_reg <= sync1_reg;
      sample_reg <= sample;
      sample_w4_reg <= w4_reg;
      acc_reg <= acc_next;
      nbits_reg <= nbits_next;
      push_valid_reg <= push_valid_next;
      push_data_reg <= push_data_next;
      refused_reg <= refused_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  assign busy = busy_reg;
  assign fetch_refused = refused_reg;
  assign cs_n = cs_n_reg;
  assign sclk = sclk_reg;
  assign io_out = io_out_reg;
  assign io_oe_n = oe_n_reg;
  assign rx_data = out_data_reg;
  assign rx_valid = out_valid_reg;

endmodule

// *** verification/seq_monitor.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module seq_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manual_mode,
  input wire logic start,
  input wire logic fetch_req,
  input wire logic rx_ready,
  input wire logic busy,
  input wire logic fetch_refused,
  input wire logic cs_n,
  input wire logic sclk,
  input wire seq_pkg::quad_t io_oe_n,
  input wire seq_pkg::byte_t rx_data,
  input wire logic rx_valid
);
  import seq_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Command framing
  property p_start;
    start && manual_mode && !busy |=> busy && !cs_n && io_oe_n == 4'hE;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_mode_off;
    !manual_mode && !busy |=> !busy;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("start in mapped mode");
  property p_fetch;
    1'b1 |=> fetch_refused == $past(manual_mode && fetch_req);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch refusal wrong");
  property p_idle_sclk;
    cs_n |-> !sclk;
  endproperty
  a_idle_sclk: assert property (p_idle_sclk) else $error("sclk runs unselected");
  property p_idle_oe;
    cs_n |-> io_oe_n == 4'hF;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("pins driven unselected");
  property p_sclk_high;
    $rose(sclk) |=> sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("short sclk high");
  property p_end;
    $rose(cs_n) |-> busy ##[1:3] !busy;
  endproperty
  a_end: assert property (p_end) else $error("busy end wrong");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte dropped");

  // Main scenarios reached
  c_start: cover property (start && manual_mode && !busy);
  c_rx: cover property (rx_valid && rx_ready);
  c_fetch: cover property (fetch_refused);
endmodule

bind flash_cmd_sequencer seq_monitor mon (.clk, .rst_n, .manual_mode, .start, .fetch_req,
  .rx_ready, .busy, .fetch_refused, .cs_n, .sclk, .io_oe_n, .rx_data, .rx_valid);

// *** verification/flash_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Flash read responder
// ----------------------------------------
module flash_model (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_w,
  input wire logic [7:0] pre,
  input wire logic quad,
  input wire logic ddr,
  output logic [3:0] io_drv,
  output logic [7:0] cmd_seen
);
  int n;
  logic sclk_d;

  // Data unit for sampling edge e; filler before the data phase
  function automatic logic [3:0] unit(input int e);
    logic [7:0] b;
    b = 8'(e / (quad ? 2 : 8) * 29 + 90);
    if (e < 0) return 4'(e);
    if (quad) return (e % 2) ? b[3:0] : b[7:4];
    return {4{b[7 - e % 8]}};
  endfunction

  // Edge follower; a released bus never keeps its last level
  initial io_drv = 4'h0;
  always @(negedge clk) begin
    sclk_d <= sclk;
    if (cs_n) begin
      n <= 0;
      io_drv <= ~io_drv;
    end else if (sclk !== sclk_d) begin
      n <= n + 1;
      if (sclk && n < 16) cmd_seen <= {cmd_seen[6:0], io_w[0]};
      if (ddr || !sclk) io_drv <= unit(ddr ? n + 1 - 2 * int'(pre) : (n + 1 - 2 * int'(pre)) / 2);
    end
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module tb_top;
  import seq_pkg::*;
  logic clk, rst_n, manual_mode, start, addr_en, addr_32, addr_quad, opt_quad;
  logic dummy_en, dummy_quad, data_quad, data_ddr, fetch_req, rx_ready;
  logic busy, fetch_refused, cs_n, sclk, rx_valid;
  logic [2:0] opt_count, dummy_cycles;
  logic [15:0] data_bytes;
  logic [31:0] addr;
  logic [7:0] pre, cmd_seen;
  byte_t cmd_code, option_byte_first, option_byte_second, option_byte_third;
  byte_t option_byte_fourth, rx_data;
  quad_t io_in, io_out, io_oe_n, io_drv;
  byte_t exp_q[$];
  int errors, checks;

  // Wire level: the sequencer wins where it drives
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & io_drv);

  flash_cmd_sequencer dut (.clk, .rst_n, .manual_mode, .start, .cmd_code, .addr_en, .addr,
    .addr_32, .addr_quad, .opt_count, .opt_quad, .option_byte_first, .option_byte_second,
    .option_byte_third, .option_byte_fourth, .dummy_en, .dummy_quad, .dummy_cycles,
    .data_quad, .data_ddr, .data_bytes, .fetch_req, .io_in, .rx_ready, .busy,
    .fetch_refused, .cs_n, .sclk, .io_out, .io_oe_n, .rx_data, .rx_valid);
  flash_model model (.clk, .cs_n, .sclk, .io_w(io_in), .pre, .quad(data_quad),
    .ddr(data_ddr), .io_drv, .cmd_seen);

  function automatic bit bad(input bit c);
    checks++;
    return c;
  endfunction

  task automatic fail(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic test_done();
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic give_up();
    fail("timeout");
    test_done();
  endtask

  // One read command; config varies with i
  task automatic run(input int i);
    int oc;
    cmd_code = $urandom;
    addr = $urandom;
    {option_byte_first, option_byte_second, option_byte_third, option_byte_fourth} = $urandom;
    {addr_en, addr_32, addr_quad} = {i != 5, i[0] ^ i[1], i > 7};
    {opt_count, opt_quad, dummy_en, dummy_quad} = {3'(i % 6), 1'($urandom), i % 3 != 0, i[1]};
    dummy_cycles = i[2] ? 3'h7 : 3'(i);
    {data_quad, data_ddr, data_bytes} = {i[0], i[2], 16'h000C};
    oc = opt_count > 4 ? 4 : opt_count;
    pre = 8'(8 + (addr_en ? (addr_32 ? 32 : 24) / (addr_quad ? 4 : 1) : 0)
      + oc * (opt_quad ? 2 : 8) + (dummy_en ? dummy_cycles + 1 : 0));
    for (int k = 0; k < 12; k++) exp_q.push_back(byte_t'(k * 29 + 90));
    // Start held on while busy must not restart
    start = 1;
    repeat (3) @(negedge clk);
    start = 0;
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k > 9000) give_up();
      @(negedge clk);
    end
    if (bad(cmd_seen !== cmd_code)) fail("command byte");
    for (int k = 0; exp_q.size() > 0; k++) begin
      if (k > 300) give_up();
      @(negedge clk);
    end
  endtask

  always #2 clk = ~clk;

  // Consumer stalls often, so the buffer fills and sclk stretches
  always @(negedge clk) begin
    rx_ready <= $urandom_range(3) == 0;
    fetch_req <= $urandom;
  end

  // Each accepted byte retires the oldest expected one
  always @(posedge clk) begin
    if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (bad(exp_q.size() == 0 || rx_data !== exp_q[0])) fail("rx byte");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    {clk, rst_n, start, fetch_req, rx_ready, addr_en, addr_32, addr_quad, opt_quad} = '0;
    {dummy_en, dummy_quad, data_quad, data_ddr, opt_count, dummy_cycles, addr} = '0;
    {cmd_code, option_byte_first, option_byte_second, option_byte_third} = '0;
    {option_byte_fourth, manual_mode, data_bytes, pre} = '0;
    void'($urandom(60996));
    repeat (20) @(negedge clk);
    rst_n = 1;
    start = 1;
    @(negedge clk);
    start = 0;
    repeat (3) @(negedge clk);
    if (bad(busy !== 1'b0)) fail("start in mapped mode");
    manual_mode = 1;
    for (int i = 0; i < 12; i++) run(i);
    test_done();
  end
endmodule
